// ### ctu_pkg.sv
// Constants for the charge-time unit: register map, field positions, codes.
// Assumes one 100 MHz system clock and Avalon-MM byte addressing.
// How it works
// R1 - Any sleep forces the current source off
// R2 - Idle with stop bit clear keeps running
// R3 - Idle with stop bit set drops current
// R4 - Reset clears every register to default
// R5 - Reset abandons measurement, keeps no result
// R6 - Software reconfigures unit after each reset
// R7 - Software discharges circuit via grounding bit
// R8 - Enable bit turns the unit on/off; the converter trigger still fires when software sets second status
// R9 - Time generation bit enables delay pulses
// R10 - Edge gate bit passes or blocks edges
// R11 - Order bit: second edge needs first
// R12 - Grounding bit grounds the source output
// R13 - Trigger bit enables converter trigger output
// R14 - Second edge polarity: one rising, zero falling
// R15 - Second source: pinA, pinB, compare, timer
// R16 - First edge polarity: one rising, zero falling
// R17 - First source uses same encoding
// R18 - Second edge status set by qualified edge
// R19 - First edge status set by qualified edge
// R20 - Six-bit signed trim adjusts the current
// R21 - Range: off, base, ten, hundred times
// R22 - Software charges by pulsing first status
// R23 - Delay pulse when capacitor reaches reference
// R24 - Current flows only in the charge window
// R25 - One-clock converter trigger on second edge
package ctu_pkg;
    // Bus geometry: printed offsets are indices, byte address is four times
    localparam int unsigned ADDR_W      = 14;
    localparam int unsigned IDX_W       = 12;
    localparam logic [11:0] IDX_CURRENT = 12'hfb1;
    localparam logic [11:0] IDX_EDGE    = 12'hfb2;
    localparam logic [11:0] IDX_CTRL    = 12'hfb3;
    localparam logic [7:0]  REG_RESET   = 8'h00;

    // Control high fields
    localparam int unsigned CH_ON    = 7;
    localparam int unsigned CH_SIDL  = 5;
    localparam int unsigned CH_DELAY_PULSE_ON  = 4;
    localparam int unsigned CH_GATE  = 3;
    localparam int unsigned CH_ORDER = 2;
    localparam int unsigned CH_GND   = 1;
    localparam int unsigned CH_TRIG  = 0;
    localparam logic [7:0]  CH_WMASK = 8'hbf;

    // Edge select and status fields
    localparam int unsigned CL_POL2    = 7;
    localparam int unsigned CL_SEL2_HI = 6;
    localparam int unsigned CL_SEL2_LO = 5;
    localparam int unsigned CL_POL1    = 4;
    localparam int unsigned CL_SEL1_HI = 3;
    localparam int unsigned CL_SEL1_LO = 2;
    localparam int unsigned CL_SEEN2   = 1;
    localparam int unsigned CL_SEEN1   = 0;

    // Current source fields
    localparam int unsigned CI_TRIM_HI = 7;
    localparam int unsigned CI_TRIM_LO = 2;
    localparam int unsigned CI_RNG_HI  = 1;
    localparam int unsigned CI_RNG_LO  = 0;
    localparam logic [1:0]  RNG_OFF    = 2'h0;

    // Edge source codes double as index into the source vector
    localparam logic [1:0]  SRC_TIMER   = 2'h0;
    localparam logic [1:0]  SRC_COMPARE = 2'h1;
    localparam logic [1:0]  SRC_PIN_B   = 2'h2;
    localparam logic [1:0]  SRC_PIN_A   = 2'h3;
    localparam int unsigned N_SRC       = 4;
    localparam int unsigned N_ASYNC     = 3;

    typedef enum logic [1:0] {
        CTU_RUN,
        CTU_IDLE_STOP,
        CTU_SLEEP
    } ctu_power_type;
endpackage

// ### ctu_sync2.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input is a level that stays for more than one clock.
`timescale 1ns/10ps
`default_nettype none
module ctu_sync2 (
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;

    // First flop feeds only the second
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule
`default_nettype wire

// ### ctu_top.sv
// Charge-time unit control: edge qualification, status, current gating.
// Assumes Avalon-MM master on sys_clk_i; pins and comparator are async.
`timescale 1ns/10ps
`default_nettype none
module ctu_top
    import ctu_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              resetn_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic [31:0]            avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire logic              edge_pin_a_i,
    input  wire logic              edge_pin_b_i,
    input  wire logic              compare_unit_output_i,
    input  wire logic              timer_one_i,
    input  wire logic              comparator_trip_i,
    input  wire logic              sleep_i,
    input  wire logic              idle_i,
    output logic                   current_on_o,
    output logic [1:0]             current_range_o,
    output logic [5:0]             current_trim_o,
    output logic                   source_ground_o,
    output logic                   delay_pulse_pin_o,
    output logic                   converter_trigger_o
);
    logic [7:0]         ctl_high;
    logic [7:0]         edge_sel;
    logic [7:0]         cur_ctl;
    logic               ack;
    logic [IDX_W-1:0]   idx;
    logic               wr_en;
    logic [N_ASYNC-1:0] async_raw;
    logic [N_ASYNC-1:0] async_syn;
    logic [N_SRC-1:0]   src_now;
    logic [N_SRC-1:0]   src_prev;
    logic               trip_prev;
    logic               seen2_prev;
    logic               hit1;
    logic               hit2;
    logic               gate;
    ctu_power_type      power;
    logic               next_current_on;
    logic               next_pulse;
    logic               next_trigger;

    // Edge match on the selected source with the selected polarity
    function automatic logic edge_hit(input logic [1:0]       sel,
                                      input logic             pol,
                                      input logic [N_SRC-1:0] now,
                                      input logic [N_SRC-1:0] prev);
        logic n;
        logic p;
        n = now[sel];
        p = prev[sel];
        edge_hit = pol ? (n & ~p) : (~n & p);
    endfunction

    // Async sources: two pins and the comparator
    assign async_raw = {comparator_trip_i, edge_pin_a_i, edge_pin_b_i};

    genvar g;
    generate
        for (g = 0; g < N_ASYNC; g++) begin : g_sync
            ctu_sync2 u_sync (
                .sys_clk_i (sys_clk_i),
                .resetn_i  (resetn_i),
                .d_i       (async_raw[g]),
                .q_o       (async_syn[g])
            );
        end
    endgenerate

    // Source vector indexed by the select code
    always_comb begin
        src_now              = '0;
        src_now[SRC_PIN_A]   = async_syn[1];
        src_now[SRC_PIN_B]   = async_syn[0];
        src_now[SRC_COMPARE] = compare_unit_output_i;
        src_now[SRC_TIMER]   = timer_one_i;
    end

    // Bus slave: one wait cycle, then the access completes
    assign idx               = avs_address_i[ADDR_W-1:2];
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
    assign wr_en             = avs_write_i & ack & avs_byteenable_i[0];

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read_i | avs_write_i) & ~ack;
        end
    end

    // Read data captured in the wait cycle; unmapped reads return zero
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && !ack) begin
            unique case (idx)
                IDX_CTRL:    avs_readdata_o <= {24'h000000, ctl_high};
                IDX_EDGE:    avs_readdata_o <= {24'h000000, edge_sel};
                IDX_CURRENT: avs_readdata_o <= {24'h000000, cur_ctl};
                default:     avs_readdata_o <= '0;
            endcase
        end
    end

    // Control high; unimplemented bit six stays zero
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ctl_high <= REG_RESET; // R4 R8
        end else if (wr_en && idx == IDX_CTRL) begin
            ctl_high <= avs_writedata_i[7:0] & CH_WMASK;
        end
    end

    // Current source control
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            cur_ctl <= REG_RESET; // R4
        end else if (wr_en && idx == IDX_CURRENT) begin
            cur_ctl <= avs_writedata_i[7:0];
        end
    end

    // Edge qualification; only an enabled unit with an open gate sees edges
    assign gate = ctl_high[CH_ON] & ctl_high[CH_GATE]; // R10 R8
    assign hit1 = gate & edge_hit(edge_sel[CL_SEL1_HI:CL_SEL1_LO], // R17
                                  edge_sel[CL_POL1], src_now, src_prev); // R16
    assign hit2 = gate & edge_hit(edge_sel[CL_SEL2_HI:CL_SEL2_LO], // R15
                                  edge_sel[CL_POL2], src_now, src_prev) // R14
                & (~ctl_high[CH_ORDER] | edge_sel[CL_SEEN1]); // R11

    // Edge select and status; a hardware set beats a software clear
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            edge_sel <= REG_RESET; // R4 R5
        end else begin
            if (wr_en && idx == IDX_EDGE) begin
                edge_sel <= avs_writedata_i[7:0];
            end
            if (hit1) begin
                edge_sel[CL_SEEN1] <= 1'b1; // R19
            end
            if (hit2) begin
                edge_sel[CL_SEEN2] <= 1'b1; // R18
            end
        end
    end

    // History for edge detection
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            src_prev   <= '0;
            trip_prev  <= 1'b0;
            seen2_prev <= 1'b0;
        end else begin
            src_prev   <= src_now;
            trip_prev  <= async_syn[2];
            seen2_prev <= edge_sel[CL_SEEN2];
        end
    end

    // Power state from the core's low-power requests
    always_comb begin
        if (sleep_i) begin
            power = CTU_SLEEP; // R1
        end else if (idle_i && ctl_high[CH_SIDL]) begin
            power = CTU_IDLE_STOP; // R3
        end else begin
            power = CTU_RUN; // R2
        end
    end

    // Charge window; trim only scales the current, never gates it
    always_comb begin
        next_current_on = 1'b0;
        unique case (power)
            CTU_SLEEP:     next_current_on = 1'b0; // R1
            CTU_IDLE_STOP: next_current_on = 1'b0; // R3
            CTU_RUN:       next_current_on = ctl_high[CH_ON]
                                           & (cur_ctl[CI_RNG_HI:CI_RNG_LO] != RNG_OFF) // R21
                                           & edge_sel[CL_SEEN1]
                                           & ~edge_sel[CL_SEEN2]
                                           & ~ctl_high[CH_GND]; // R24 R12
        endcase
    end

    // Delay pulse on comparator rise while charging in delay mode
    assign next_pulse = ctl_high[CH_ON] & ctl_high[CH_DELAY_PULSE_ON] // R9
                      & edge_sel[CL_SEEN1] & async_syn[2] & ~trip_prev; // R23

    // Converter trigger on the rise of second status
    assign next_trigger = ctl_high[CH_TRIG] // R13
                        & edge_sel[CL_SEEN2] & ~seen2_prev; // R25

    // Registered outputs toward the analog source and converter
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            current_on_o        <= 1'b0;
            delay_pulse_pin_o   <= 1'b0;
            converter_trigger_o <= 1'b0;
        end else begin
            current_on_o        <= next_current_on;
            delay_pulse_pin_o   <= next_pulse;
            converter_trigger_o <= next_trigger;
        end
    end

    // Static settings straight from register flops
    assign current_range_o = cur_ctl[CI_RNG_HI:CI_RNG_LO]; // R21
    assign current_trim_o  = cur_ctl[CI_TRIM_HI:CI_TRIM_LO]; // R20
    assign source_ground_o = ctl_high[CH_GND]; // R12

    // Checks
    AST_SLEEP_OFF: assert property ( // R1
        @(posedge sys_clk_i) disable iff (!resetn_i)
        sleep_i |=> !current_on_o)
        else $error("current on after sleep");

    AST_IDLE_RUN: assert property ( // R2
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (idle_i && !sleep_i && !ctl_high[CH_SIDL] && ctl_high[CH_ON]
         && cur_ctl[CI_RNG_HI:CI_RNG_LO] != RNG_OFF && edge_sel[CL_SEEN1]
         && !edge_sel[CL_SEEN2] && !ctl_high[CH_GND]) |=> current_on_o)
        else $error("idle without stop dropped current");

    AST_IDLE_STOP: assert property ( // R3
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (idle_i && ctl_high[CH_SIDL]) |=> !current_on_o)
        else $error("current on in stopped idle");

    AST_RESET_CLEAR: assert property ( // R4
        @(posedge sys_clk_i)
        !resetn_i |=> (ctl_high == REG_RESET && edge_sel == REG_RESET
                       && cur_ctl == REG_RESET && !current_on_o))
        else $error("registers not cleared by reset");

    AST_GATE_BLOCK: assert property ( // R10
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (!ctl_high[CH_GATE] && !edge_sel[CL_SEEN1] && !avs_write_i)
        |=> !edge_sel[CL_SEEN1])
        else $error("edge passed a closed gate");

    AST_ORDER: assert property ( // R11
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (ctl_high[CH_ORDER] && !edge_sel[CL_SEEN1] && !edge_sel[CL_SEEN2]
         && !avs_write_i) |=> !edge_sel[CL_SEEN2])
        else $error("second edge before first");

    AST_GROUND: assert property ( // R12
        @(posedge sys_clk_i) disable iff (!resetn_i)
        source_ground_o |=> !current_on_o)
        else $error("charging while grounded");

    AST_SEEN1_SET: assert property ( // R19
        @(posedge sys_clk_i) disable iff (!resetn_i)
        hit1 |=> edge_sel[CL_SEEN1])
        else $error("first edge not recorded");

    AST_RANGE_OFF: assert property ( // R21
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (cur_ctl[CI_RNG_HI:CI_RNG_LO] == RNG_OFF) |=> !current_on_o)
        else $error("current on with range off");

    AST_TRIG_PULSE: assert property ( // R25
        @(posedge sys_clk_i) disable iff (!resetn_i)
        converter_trigger_o |-> ($past(ctl_high[CH_TRIG]) && seen2_prev
                                 && !$past(seen2_prev) && !$past(converter_trigger_o)))
        else $error("trigger without rise of second status");

    AST_PULSE_EN: assert property ( // R9
        @(posedge sys_clk_i) disable iff (!resetn_i)
        delay_pulse_pin_o |-> ($past(ctl_high[CH_DELAY_PULSE_ON]) && !$past(delay_pulse_pin_o)))
        else $error("delay pulse while disabled");

    AST_BUS_WAIT: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        ((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o)
        else $error("bus wait longer than one cycle");

    // Status history: bits rise only by a qualified edge or a bus write
    AST_SEEN2_SET: assert property ( // R18
        @(posedge sys_clk_i) disable iff (!resetn_i)
        hit2 |=> edge_sel[CL_SEEN2])
        else $error("second edge not recorded");

    AST_SEEN2_ROSE: assert property ( // R18
        @(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(edge_sel[CL_SEEN2]) |-> ($past(hit2)
                                       || ($past(wr_en) && $past(idx) == IDX_EDGE)))
        else $error("second status rose with no cause");

    AST_SEEN1_HOLD: assert property ( // R19
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (edge_sel[CL_SEEN1] && !(wr_en && idx == IDX_EDGE)) |=> edge_sel[CL_SEEN1])
        else $error("first status lost without a write");

    AST_GATE_BLOCK2: assert property ( // R10
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (!ctl_high[CH_GATE] && !edge_sel[CL_SEEN2] && !avs_write_i)
        |=> !edge_sel[CL_SEEN2])
        else $error("second edge passed a closed gate");

    // Charge window both ways; a missed term would leak current
    AST_CHARGE_WIN: assert property ( // R24
        @(posedge sys_clk_i) disable iff (!resetn_i)
        current_on_o |-> ($past(ctl_high[CH_ON]) && $past(edge_sel[CL_SEEN1])
                          && !$past(edge_sel[CL_SEEN2]) && !$past(ctl_high[CH_GND])))
        else $error("current on outside the charge window");

    AST_CHARGE_ON: assert property ( // R24
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (!sleep_i && !idle_i && ctl_high[CH_ON] && cur_ctl[CI_RNG_HI:CI_RNG_LO] != RNG_OFF
         && edge_sel[CL_SEEN1] && !edge_sel[CL_SEEN2] && !ctl_high[CH_GND])
        |=> current_on_o)
        else $error("current off inside the charge window");

    AST_UNIT_OFF: assert property ( // R8
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !ctl_high[CH_ON] |=> (!current_on_o && !delay_pulse_pin_o))
        else $error("disabled unit still active");

    // Pulse outputs follow their enables
    AST_DELAY_PULSE_ON_OFF: assert property ( // R9
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !ctl_high[CH_DELAY_PULSE_ON] |=> !delay_pulse_pin_o)
        else $error("delay pulse with generation off");

    AST_PULSE_TRIP: assert property ( // R23
        @(posedge sys_clk_i) disable iff (!resetn_i)
        delay_pulse_pin_o |-> (trip_prev && !$past(trip_prev) && $past(edge_sel[CL_SEEN1])))
        else $error("delay pulse without comparator rise");

    AST_TRIG_OFF: assert property ( // R13
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !ctl_high[CH_TRIG] |=> !converter_trigger_o)
        else $error("trigger with trigger bit clear");

    AST_TRIG_FIRE: assert property ( // R25
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (ctl_high[CH_TRIG] && edge_sel[CL_SEEN2] && !seen2_prev) |=> converter_trigger_o)
        else $error("trigger missed on second status rise");

    AST_RESET_OUT: assert property ( // R5
        @(posedge sys_clk_i)
        !resetn_i |=> (!delay_pulse_pin_o && !converter_trigger_o))
        else $error("pulse output survived reset");
endmodule
`default_nettype wire

// ### ctu_far_side.sv
// Far-side model: the four edge sources and the charged capacitor with its comparator.
// Assumes the bench commands source levels and the block drives the current enable.
`timescale 1ns/10ps
`default_nettype none
module ctu_far_side #(
    parameter int TRIP_CYCLES = 10
) (
    input  wire logic       sys_clk_i,
    input  wire logic [3:0] level_i,
    input  wire logic       current_on_i,
    input  wire logic       source_ground_i,
    output logic            edge_pin_a_o,
    output logic            edge_pin_b_o,
    output logic            compare_unit_output_o,
    output logic            timer_one_o,
    output logic            comparator_trip_o
);
    int charge = 0;

    // Source levels follow the select code order
    assign timer_one_o           = level_i[0];
    assign compare_unit_output_o = level_i[1];
    assign edge_pin_b_o          = level_i[2];
    assign edge_pin_a_o          = level_i[3];

    // Charge survives a block reset; only grounding drains it
    always @(posedge sys_clk_i) begin
        if (source_ground_i)
            charge <= 0;
        else if (current_on_i && charge < TRIP_CYCLES)
            charge <= charge + 1;
    end

    // Comparator trips once the capacitor reaches the reference
    assign comparator_trip_o = (charge >= TRIP_CYCLES);
endmodule
`default_nettype wire

// ### charge_time_edge_control_tb_top.sv
// Self-checking bench for the charge-time unit control block.
// Assumes ctu_pkg, ctu_top and ctu_far_side are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
    begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("FAIL t=%0t got %h exp %h", $time, (got), (exp)); end end
module charge_time_edge_control_tb_top;
    import ctu_pkg::*;
    logic              sys_clk_i = 1'b0;
    logic              resetn_i = 1'b0;
    logic [ADDR_W-1:0] avs_address_i = '0;
    logic              avs_read_i = 1'b0;
    logic              avs_write_i = 1'b0;
    logic [31:0]       avs_writedata_i = '0;
    logic [3:0]        avs_byteenable_i = 4'h0;
    logic [31:0]       avs_readdata_o;
    logic              avs_waitrequest_o;
    logic              edge_pin_a_i, edge_pin_b_i, compare_unit_output_i, timer_one_i;
    logic              comparator_trip_i;
    logic              sleep_i = 1'b0;
    logic              idle_i = 1'b0;
    logic              current_on_o, source_ground_o, delay_pulse_pin_o, converter_trigger_o;
    logic [1:0]        current_range_o;
    logic [5:0]        current_trim_o;
    logic [3:0]        level = 4'h0;
    logic [7:0]        rd;
    logic [7:0]        cfg;
    logic [7:0]        cur_tab [4] = '{8'h7d, 8'h86, 8'h03, 8'h01};
    int                fail_count = 0;
    int                samples_checked = 0;
    int                trig_cnt = 0;
    int                pulse_cnt = 0;

    ctu_top uut (.sys_clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .edge_pin_a_i, .edge_pin_b_i, .compare_unit_output_i, .timer_one_i,
        .comparator_trip_i, .sleep_i, .idle_i, .current_on_o, .current_range_o,
        .current_trim_o, .source_ground_o, .delay_pulse_pin_o, .converter_trigger_o);

    ctu_far_side far (.sys_clk_i(sys_clk_i), .level_i(level), .current_on_i(current_on_o),
        .source_ground_i(source_ground_o), .edge_pin_a_o(edge_pin_a_i),
        .edge_pin_b_o(edge_pin_b_i), .compare_unit_output_o(compare_unit_output_i),
        .timer_one_o(timer_one_i), .comparator_trip_o(comparator_trip_i));

    // 100 MHz clock
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // Pulse counters; a pulse wider than one clock shows as an extra count
    always @(posedge sys_clk_i) begin
        if (converter_trigger_o === 1'b1) trig_cnt++;
        if (delay_pulse_pin_o === 1'b1) pulse_cnt++;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // One bus access; holds the request until waitrequest is seen low
    task automatic xfer(input logic w, input logic [11:0] idx, input logic [7:0] wd,
                        input logic [3:0] be);
        avs_address_i    <= {idx, 2'b00};
        avs_write_i      <= w;
        avs_read_i       <= ~w;
        avs_writedata_i  <= {24'h0, wd};
        avs_byteenable_i <= be;
        do begin
            @(posedge sys_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o[7:0];
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
        xfer(1'b1, idx, wd, 4'h1);
    endtask

    task automatic chk_reg(input logic [11:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00, 4'h1);
        `CHK(rd, exp)
    endtask

    // Move one source level, then let synchroniser and detector settle
    task automatic drive(input int s, input logic v);
        level[s] <= v;
        cyc(6);
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fail_count++;
        $display("FAIL t=%0t watchdog expired", $time);
        give_verdict();
    end

    initial begin
        repeat (12) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        @(posedge sys_clk_i);
        chk_reg(IDX_CTRL, 8'h00);
        chk_reg(IDX_EDGE, 8'h00);
        chk_reg(IDX_CURRENT, 8'h00);
        wr(IDX_CTRL, 8'hff);
        chk_reg(IDX_CTRL, 8'hbf);
        `CHK(source_ground_o, 1'b1)
        wr(IDX_CTRL, 8'h00);
        wr(IDX_EDGE, 8'hfc);
        chk_reg(IDX_EDGE, 8'hfc);
        foreach (cur_tab[i]) begin
            wr(IDX_CURRENT, cur_tab[i]);
            chk_reg(IDX_CURRENT, cur_tab[i]);
            `CHK(current_trim_o, cur_tab[i][7:2])
            `CHK(current_range_o, cur_tab[i][1:0])
        end
        // Refused writes: no byte enable, unmapped index
        xfer(1'b1, IDX_CURRENT, 8'h55, 4'h0);
        chk_reg(IDX_CURRENT, 8'h01);
        xfer(1'b1, 12'hfb4, 8'h55, 4'h1);
        chk_reg(12'hfb4, 8'h00);
        end_test("registers");

        // Every source and polarity; wrong edge, and for rising polarity a closed gate, leave status clear
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                cfg = {p[0], s[1:0], p[0], s[1:0], 2'b00};
                wr(IDX_CTRL, 8'h80);
                wr(IDX_EDGE, cfg);
                drive(s, p[0]);
                wr(IDX_CTRL, 8'h88);
                drive(s, ~p[0]);
                chk_reg(IDX_EDGE, cfg);
                drive(s, p[0]);
                chk_reg(IDX_EDGE, cfg | 8'h03);
            end
        end
        end_test("edges");

        // Ordering, charge window and converter trigger
        wr(IDX_CTRL, 8'h80);
        level <= 4'h0;
        cyc(6);
        wr(IDX_EDGE, 8'hb0);
        wr(IDX_CTRL, 8'h8d);
        drive(1, 1'b1);
        chk_reg(IDX_EDGE, 8'hb0);
        `CHK(trig_cnt, 0)
        drive(0, 1'b1);
        chk_reg(IDX_EDGE, 8'hb1);
        `CHK(current_on_o, 1'b1)
        drive(1, 1'b0);
        drive(1, 1'b1);
        chk_reg(IDX_EDGE, 8'hb3);
        `CHK(current_on_o, 1'b0)
        `CHK(trig_cnt, 1)
        wr(IDX_CTRL, 8'h8c);
        wr(IDX_EDGE, 8'hb0);
        wr(IDX_EDGE, 8'hb2);
        cyc(4);
        `CHK(trig_cnt, 1)
        end_test("order");

        // Delay pulse with and without time generation; discharge first
        wr(IDX_CTRL, 8'h92);
        wr(IDX_CTRL, 8'h90);
        wr(IDX_EDGE, 8'h01);
        cyc(40);
        `CHK(pulse_cnt, 1)
        wr(IDX_EDGE, 8'h00);
        wr(IDX_CTRL, 8'h82);
        wr(IDX_CTRL, 8'h80);
        wr(IDX_EDGE, 8'h01);
        cyc(40);
        `CHK(pulse_cnt, 1)
        end_test("delay");

        // Power modes, grounding, range and enable against the charge window
        sleep_i <= 1'b1;
        cyc(3);
        `CHK(current_on_o, 1'b0)
        sleep_i <= 1'b0;
        idle_i  <= 1'b1;
        cyc(3);
        `CHK(current_on_o, 1'b1)
        wr(IDX_CTRL, 8'ha0);
        cyc(2);
        `CHK(current_on_o, 1'b0)
        idle_i <= 1'b0;
        cyc(3);
        `CHK(current_on_o, 1'b1)
        wr(IDX_CTRL, 8'h82);
        cyc(2);
        `CHK(current_on_o, 1'b0)
        wr(IDX_CTRL, 8'h80);
        wr(IDX_CURRENT, 8'h00);
        cyc(2);
        `CHK(current_on_o, 1'b0)
        wr(IDX_CURRENT, 8'h01);
        wr(IDX_CTRL, 8'h00);
        cyc(2);
        `CHK(current_on_o, 1'b0)
        end_test("power");

        // Reset in mid-measurement drops the current and every setting
        wr(IDX_CTRL, 8'h80);
        cyc(2);
        `CHK(current_on_o, 1'b1)
        resetn_i <= 1'b0;
        cyc(3);
        resetn_i <= 1'b1;
        @(posedge sys_clk_i);
        `CHK(current_on_o, 1'b0)
        chk_reg(IDX_EDGE, 8'h00);
        chk_reg(IDX_CTRL, 8'h00);
        chk_reg(IDX_CURRENT, 8'h00);
        wr(IDX_CURRENT, 8'h01);
        wr(IDX_CTRL, 8'h80);
        wr(IDX_EDGE, 8'h01);
        cyc(2);
        `CHK(current_on_o, 1'b1)
        end_test("reset");
        give_verdict();
    end
endmodule
`default_nettype wire
